//--- hw/timer16_pkg.sv
// timer16_pkg: register map, field positions, encodings and bus carriers
// for the 16-bit compare timer; assumes byte addresses on a 32-bit Avalon bus.
package timer16_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned PRE_W   = 10;
   localparam int unsigned N_CH    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_ACTION = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FORCE  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_CMP_A  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CMP_B  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_CAPT   = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_PORT   = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned CTRL_MODE_LSB = 0;   // waveform_mode_select, 4 bits
   localparam int unsigned CTRL_CLK_LSB  = 4;   // clock select, 3 bits
   localparam int unsigned ACT_A_LSB     = 0;   // compare_output_action_a
   localparam int unsigned ACT_B_LSB     = 2;   // compare_output_action_b
   localparam int unsigned FORCE_A_BIT   = 0;   // force_compare_strobe bits
   localparam int unsigned FLAG_OVF_BIT  = 0;
   localparam int unsigned FLAG_CMP_LSB  = 1;   // compare_flag_a, then b
   localparam int unsigned FLAG_CAPT_BIT = 3;
   localparam int unsigned PORT_VAL_LSB  = 0;   // port output value a, b
   localparam int unsigned PORT_DIR_LSB  = 2;   // output_pin_direction_bit a, b
   localparam int unsigned STAT_STATE_LSB = 0;  // compare_output_state a, b
   localparam int unsigned STAT_PIN_LSB   = 2;  // pin level driven a, b

   ////////////////////////////////////////////////////////////////////////////
   // encodings
   localparam logic [3:0] MODE_NORMAL   = 4'h0;
   localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPT = 4'hC;

   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

   localparam logic [2:0] CLK_STOP    = 3'h0;
   localparam logic [2:0] CLK_DIV1    = 3'h1;
   localparam logic [2:0] CLK_DIV8    = 3'h2;
   localparam logic [2:0] CLK_DIV64   = 3'h3;
   localparam logic [2:0] CLK_DIV256  = 3'h4;
   localparam logic [2:0] CLK_DIV1024 = 3'h5;

   localparam logic [PRE_W-1:0] PRE_MASK_8    = 10'h007;
   localparam logic [PRE_W-1:0] PRE_MASK_64   = 10'h03F;
   localparam logic [PRE_W-1:0] PRE_MASK_256  = 10'h0FF;
   localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [CNT_W-1:0]  COUNT_RST = 16'h0000;
   localparam logic [N_CH-1:0]   STATE_RST = 2'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } avmm_req_s;

   typedef struct packed {
      logic [N_CH-1:0] out;
      logic [N_CH-1:0] oe_n;
   } pin_drive_s;

   typedef enum logic {PH_IDLE, PH_ANSWER} bus_phase_e;

endpackage

//--- hw/timer16_compare_output.sv
// timer16_compare_output: 16-bit timer with Normal and clear-on-match
// modes, two compare channels and their output states with port override.
// assumes an Avalon-MM master on clk_sys and a port pad that resolves
// its level from out and an active-low enable.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

// What this block does
// - reset clears compare output state to zero
// - nonzero action overrides port value with state
// - port direction bit still gates the pin
// - state settable before pin output is enabled
// - action field never touches capture unit
// - action zero leaves state unchanged on match
// - new action reaches state at next match or force
// - force strobe applies action now, non-PWM
// - counting depends only on waveform mode
// - action selects set, clear or toggle
// - mode 0 counts up, wraps FFFF to 0
// - Normal: overflow flag set as count hits zero
// - hardware only sets overflow; service clears it
// - Normal: count writable any time
// - mode 4/12 clear at compare A / capture
// - top match raises compare A or capture flag
// - unbuffered top; missed top runs to wrap
// - clear-on-match, action 1 toggles state A
// - toggle rate clk/(2*N*(1+compare A))
// - clear-on-match: overflow on MAX to zero
// - compare match sets flag next timer tick
// - force skips flag and counter clear
module timer16_compare_output #(
   parameter int unsigned CNT_W = timer16_pkg::CNT_W
) (
   // clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          resetn,
   // register bus
   input  wire timer16_pkg::avmm_req_s        avs_req,
   output logic [timer16_pkg::DATA_W-1:0]     avs_readdata,
   output logic                               avs_waitrequest,
   // overflow interrupt execution acknowledge
   input  wire logic                          overflow_service,
   // compare output pins and internal states
   output timer16_pkg::pin_drive_s            pin_drive,
   output logic [timer16_pkg::N_CH-1:0]       compare_output_state
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration check: counter fits the 32-bit data path
   if (CNT_W < 2 || CNT_W > timer16_pkg::DATA_W) begin : g_bad_width
      $error("timer16_compare_output: CNT_W out of range");
   end

   localparam int unsigned NC = timer16_pkg::N_CH;
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   timer16_pkg::bus_phase_e          phase_r;
   logic [3:0]                       mode_r;
   logic [2:0]                       clk_sel_r;
   logic [2*NC-1:0]                  action_r;
   logic [CNT_W-1:0]                 count_r;
   logic [CNT_W-1:0]                 count_nxt;
   logic [CNT_W-1:0]                 cmp_r [NC];
   logic [CNT_W-1:0]                 capture_r;
   logic                             ovf_flag_r;
   logic [NC-1:0]                    cmp_flag_r;
   logic                             capt_flag_r;
   logic [NC-1:0]                    port_val_r;
   logic [NC-1:0]                    port_dir_r;
   logic [NC-1:0]                    state_r;
   logic [NC-1:0]                    state_nxt;
   logic [timer16_pkg::PRE_W-1:0]    pre_r;
   logic                             block_r;
   logic                             tick;
   logic                             non_pwm;
   logic                             clear_on_match_mode;
   logic [CNT_W-1:0]                 top;
   logic                             top_match;
   logic [NC-1:0]                    match;
   logic                             bus_req;
   logic                             wr_en;
   logic [timer16_pkg::DATA_W-1:0]   wdata;
   logic [timer16_pkg::DATA_W-1:0]   rd_mux;

   assign bus_req = avs_req.read | avs_req.write;
   assign wdata   = avs_req.writedata;
   // writes land on the edge where waitrequest is seen low
   assign wr_en   = avs_req.write & (phase_r == timer16_pkg::PH_ANSWER);

   function automatic logic wr_hit(input logic [timer16_pkg::ADDR_W-1:0] off);
      wr_hit = wr_en & (avs_req.address == off);
   endfunction

   // action applied to a current output state
   function automatic logic apply_action(input logic [1:0] act, input logic cur);
      case (act)
         timer16_pkg::ACT_TOGGLE: apply_action = ~cur;
         timer16_pkg::ACT_CLEAR:  apply_action = 1'b0;
         timer16_pkg::ACT_SET:    apply_action = 1'b1;
         default:                 apply_action = cur;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, then answer for one cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase_r         <= timer16_pkg::PH_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (phase_r)
            timer16_pkg::PH_IDLE: begin
               if (bus_req) begin
                  phase_r         <= timer16_pkg::PH_ANSWER;
                  avs_waitrequest <= 1'b0;
               end
            end
            timer16_pkg::PH_ANSWER: begin
               phase_r         <= timer16_pkg::PH_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               phase_r         <= timer16_pkg::PH_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = timer16_pkg::DATA_ZERO;
      case (avs_req.address)
         timer16_pkg::OFF_CTRL: begin
            rd_mux[timer16_pkg::CTRL_MODE_LSB +: 4] = mode_r;
            rd_mux[timer16_pkg::CTRL_CLK_LSB +: 3]  = clk_sel_r;
         end
         timer16_pkg::OFF_ACTION: rd_mux[2*NC-1:0] = action_r;
         timer16_pkg::OFF_COUNT:  rd_mux[CNT_W-1:0] = count_r;
         timer16_pkg::OFF_CMP_A:  rd_mux[CNT_W-1:0] = cmp_r[0];
         timer16_pkg::OFF_CMP_B:  rd_mux[CNT_W-1:0] = cmp_r[1];
         timer16_pkg::OFF_CAPT:   rd_mux[CNT_W-1:0] = capture_r;
         timer16_pkg::OFF_FLAGS: begin
            rd_mux[timer16_pkg::FLAG_OVF_BIT]          = ovf_flag_r;
            rd_mux[timer16_pkg::FLAG_CMP_LSB +: NC]    = cmp_flag_r;
            rd_mux[timer16_pkg::FLAG_CAPT_BIT]         = capt_flag_r;
         end
         timer16_pkg::OFF_PORT: begin
            rd_mux[timer16_pkg::PORT_VAL_LSB +: NC] = port_val_r;
            rd_mux[timer16_pkg::PORT_DIR_LSB +: NC] = port_dir_r;
         end
         timer16_pkg::OFF_STATUS: begin
            rd_mux[timer16_pkg::STAT_STATE_LSB +: NC] = state_r;
            rd_mux[timer16_pkg::STAT_PIN_LSB +: NC]   = pin_drive.out;
         end
         default: rd_mux = timer16_pkg::DATA_ZERO;
      endcase
   end

   // read data captured during the wait cycle, stands in the answer cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= timer16_pkg::DATA_ZERO;
      end else if (avs_req.read && phase_r == timer16_pkg::PH_IDLE) begin
         avs_readdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_r     <= timer16_pkg::MODE_NORMAL;
         clk_sel_r  <= timer16_pkg::CLK_STOP;
         action_r   <= '0;
         port_val_r <= '0;
         port_dir_r <= '0;
      end else begin
         if (wr_hit(timer16_pkg::OFF_CTRL)) begin
            mode_r    <= wdata[timer16_pkg::CTRL_MODE_LSB +: 4];
            clk_sel_r <= wdata[timer16_pkg::CTRL_CLK_LSB +: 3];
         end
         // stored now; selects the pin override at once, applied to the state at a match or force strobe
         if (wr_hit(timer16_pkg::OFF_ACTION)) begin
            action_r <= wdata[2*NC-1:0];
         end
         if (wr_hit(timer16_pkg::OFF_PORT)) begin
            port_val_r <= wdata[timer16_pkg::PORT_VAL_LSB +: NC];
            port_dir_r <= wdata[timer16_pkg::PORT_DIR_LSB +: NC];
         end
      end
   end

   // compare and capture values, written straight, no double buffer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmp_r[0]  <= timer16_pkg::COUNT_RST;
         cmp_r[1]  <= timer16_pkg::COUNT_RST;
         capture_r <= timer16_pkg::COUNT_RST;
      end else begin
         if (wr_hit(timer16_pkg::OFF_CMP_A)) begin
            cmp_r[0] <= wdata[CNT_W-1:0];
         end
         if (wr_hit(timer16_pkg::OFF_CMP_B)) begin
            cmp_r[1] <= wdata[CNT_W-1:0];
         end
         if (wr_hit(timer16_pkg::OFF_CAPT)) begin
            capture_r <= wdata[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler: timer tick every N system clocks
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 10'h001;
      end
   end

   always_comb begin
      case (clk_sel_r)
         timer16_pkg::CLK_DIV1:    tick = 1'b1;
         timer16_pkg::CLK_DIV8:    tick = &(pre_r | ~timer16_pkg::PRE_MASK_8);
         timer16_pkg::CLK_DIV64:   tick = &(pre_r | ~timer16_pkg::PRE_MASK_64);
         timer16_pkg::CLK_DIV256:  tick = &(pre_r | ~timer16_pkg::PRE_MASK_256);
         timer16_pkg::CLK_DIV1024: tick = &(pre_r | ~timer16_pkg::PRE_MASK_1024);
         default:                  tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // counting: only the waveform mode steers it
   assign non_pwm = (mode_r == timer16_pkg::MODE_NORMAL) |
                    (mode_r == timer16_pkg::MODE_CTC_CMP) |
                    (mode_r == timer16_pkg::MODE_CTC_CAPT);
   assign clear_on_match_mode     = (mode_r == timer16_pkg::MODE_CTC_CMP) |
                    (mode_r == timer16_pkg::MODE_CTC_CAPT);
   // top source picked by mode, never by the action field
   assign top       = (mode_r == timer16_pkg::MODE_CTC_CAPT) ? capture_r : cmp_r[0];
   assign top_match = clear_on_match_mode & ~block_r & (count_r == top);

   always_comb begin
      count_nxt = count_r;
      if (tick) begin
         if (top_match) begin
            count_nxt = timer16_pkg::COUNT_RST;
         end else begin
            count_nxt = count_r + CNT_ONE;
         end
      end
      if (wr_hit(timer16_pkg::OFF_COUNT)) begin
         count_nxt = wdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count_r <= timer16_pkg::COUNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   // a count write masks compares for the following timer tick
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         block_r <= 1'b0;
      end else if (wr_hit(timer16_pkg::OFF_COUNT)) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per channel compare match and output state
   for (genvar ch = 0; ch < NC; ch++) begin : g_ch
      assign match[ch] = ~block_r & (count_r == cmp_r[ch]);

      always_comb begin
         state_nxt[ch] = state_r[ch];
         if (non_pwm && tick && match[ch]) begin
            state_nxt[ch] = apply_action(action_r[2*ch +: 2], state_r[ch]);
         end
         if (non_pwm && wr_hit(timer16_pkg::OFF_FORCE) &&
             wdata[timer16_pkg::FORCE_A_BIT + ch]) begin
            state_nxt[ch] = apply_action(action_r[2*ch +: 2], state_r[ch]);
         end
      end

      // state kept whatever the pin direction, so it can be preset
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            state_r[ch] <= timer16_pkg::STATE_RST[ch];
         end else begin
            state_r[ch] <= state_nxt[ch];
         end
      end

      // port override and direction; pad enable is active low
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            pin_drive.out[ch]  <= 1'b0;
            pin_drive.oe_n[ch] <= 1'b1;
         end else begin
            pin_drive.out[ch]  <= (action_r[2*ch +: 2] != timer16_pkg::ACT_NONE) ?
                                  state_nxt[ch] : port_val_r[ch];
            pin_drive.oe_n[ch] <= ~port_dir_r[ch];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         compare_output_state <= timer16_pkg::STATE_RST;
      end else begin
         compare_output_state <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: hardware sets, write-one clears, set wins over clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ovf_flag_r <= 1'b0;
      end else if (tick && count_r == CNT_MAX) begin
         ovf_flag_r <= 1'b1;
      end else if (overflow_service ||
                   (wr_hit(timer16_pkg::OFF_FLAGS) && wdata[timer16_pkg::FLAG_OVF_BIT])) begin
         ovf_flag_r <= 1'b0;
      end
   end

   // compare flags set at the tick that evaluates the match
   for (genvar ch = 0; ch < NC; ch++) begin : g_flag
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            cmp_flag_r[ch] <= 1'b0;
         end else if (tick && match[ch]) begin
            cmp_flag_r[ch] <= 1'b1;
         end else if (wr_hit(timer16_pkg::OFF_FLAGS) &&
                      wdata[timer16_pkg::FLAG_CMP_LSB + ch]) begin
            cmp_flag_r[ch] <= 1'b0;
         end
      end
   end

   // capture flag marks top when the capture value defines it;
   // action bits take no part here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         capt_flag_r <= 1'b0;
      end else if (tick && top_match && mode_r == timer16_pkg::MODE_CTC_CAPT) begin
         capt_flag_r <= 1'b1;
      end else if (wr_hit(timer16_pkg::OFF_FLAGS) && wdata[timer16_pkg::FLAG_CAPT_BIT]) begin
         capt_flag_r <= 1'b0;
      end
   end

endmodule

//--- tb/timer16_pad_model.sv
// pad model: resolves the compare output pins from level and active-low enable
// assumes weak pull-ups on the pins, so a released pin reads high
`timescale 1ns/1ps
module timer16_pad_model (
   // drive from the block
   input  wire logic [1:0] out,
   input  wire logic [1:0] oe_n,
   // resolved pad level
   output logic      [1:0] level
);
   // a pin shows the drive only while enabled, else the pull-up
   assign level = (out & ~oe_n) | oe_n;
endmodule

//--- tb/timer16_compare_output_chk.sv
// checker: bus answer timing, read-back and compare output state
// assumes it is bound to timer16_compare_output and sees only its ports
`timescale 1ns/1ps
module timer16_compare_output_chk #(
   parameter int unsigned CNT_W = timer16_pkg::CNT_W
) (
   // clock and reset
   input wire logic                           clk_sys,
   input wire logic                           resetn,
   // register bus
   input wire timer16_pkg::avmm_req_s         avs_req,
   input wire logic [timer16_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                           avs_waitrequest,
   // pins and states
   input wire timer16_pkg::pin_drive_s        pin_drive,
   input wire logic [timer16_pkg::N_CH-1:0]   compare_output_state
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////////
   // a read answered in this cycle, and at which place
   sequence s_rd_ans;
      avs_req.read && !avs_waitrequest;
   endsequence
   sequence s_rd_at(logic [7:0] a);
      s_rd_ans ##0 (avs_req.address == a);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   a_state_reset: assert property ($rose(resetn) |-> compare_output_state == 2'h0)
      else $error("output state not zero after reset");
   a_reset_pins: assert property ($rose(resetn) |-> pin_drive.oe_n == 2'h3)
      else $error("pins driven right after reset");
   a_pin_follow: assert property ($changed(compare_output_state[0])
      && $past(pin_drive.out[0] == compare_output_state[0])
      |-> pin_drive.out[0] == compare_output_state[0])
      else $error("overridden pin lost the output state");
   a_status_read: assert property (s_rd_at(timer16_pkg::OFF_STATUS)
      |-> avs_readdata[1:0] == $past(compare_output_state))
      else $error("status read disagrees with output state");
   a_force_reads0: assert property (s_rd_at(timer16_pkg::OFF_FORCE)
      |-> avs_readdata == timer16_pkg::DATA_ZERO)
      else $error("force strobe read not zero");
   a_unmapped_zero: assert property (s_rd_ans ##0 (avs_req.address > timer16_pkg::OFF_STATUS)
      |-> avs_readdata == timer16_pkg::DATA_ZERO)
      else $error("unmapped read not zero");
   a_flags_rsvd: assert property (s_rd_at(timer16_pkg::OFF_FLAGS)
      |-> avs_readdata[31:4] == 28'h000_0000)
      else $error("reserved flag bits not zero");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_answer: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
endmodule

bind timer16_compare_output timer16_compare_output_chk #(.CNT_W(CNT_W)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pin_drive(pin_drive),
   .compare_output_state(compare_output_state));

//--- tb/test_timer16_compare_output.sv
// testbench for the compare timer: forced actions, pins, modes and flags
// assumes the pad model and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module test_timer16_compare_output;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_s;
   logic                    clk_sys = 1'h0;
   logic                    resetn = 1'h0;
   timer16_pkg::avmm_req_s  avs_req = '0;
   logic                    overflow_service = 1'h0;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   timer16_pkg::pin_drive_s pin_drive;
   logic [1:0]              state;
   logic [1:0]              level;
   int                      n_mismatch = 0;
   int                      checks_done = 0;
   note_s                   notes[$];

   // clock, block and pads
   always #2 clk_sys = ~clk_sys;
   timer16_compare_output dut (.clk_sys(clk_sys), .resetn(resetn), .avs_req(avs_req),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .overflow_service(overflow_service), .pin_drive(pin_drive),
      .compare_output_state(state));
   timer16_pad_model pad (.out(pin_drive.out), .oe_n(pin_drive.oe_n), .level(level));

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle: hold the request until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_req <= '{read: !w, write: w, address: a, writedata: d};
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'h0);
      avs_req.read <= 1'h0;
      avs_req.write <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'h1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      notes.push_back('{nm, e, m});
      acc(1'h0, a, 32'h0);
   endtask
   task automatic ctl(input logic [2:0] c, input logic [3:0] m);
      wr(timer16_pkg::OFF_CTRL, {25'h0, c, m});
   endtask
   // cycles until output state A changes
   task automatic half(output int n);
      logic s;
      s = state[0];
      n = 0;
      while (state[0] === s && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   // expected status word: pins, then states
   function automatic logic [31:0] stat(logic [1:0] a, logic s, logic [1:0] pv);
      return {28'h000_0000, pv[1], (a != 2'h0) ? s : pv[0], 1'h0, s};
   endfunction

   // watcher: compares each read answer with the oldest note
   always @(posedge clk_sys) begin
      if (avs_req.read && avs_waitrequest === 1'h0 && notes.size() > 0) begin
         note_s n;
         n = notes.pop_front();
         `CHK(n.nm, n.e & n.m, avs_readdata & n.m)
      end
   end

   task automatic complete_run();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial begin
      repeat (99000) @(posedge clk_sys);
      n_mismatch++;
      complete_run();
   end

   // main sequence
   initial begin
      logic [1:0]  acts[5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0}; // toggle clear set toggle none
      logic [2:0]  csel[2] = '{timer16_pkg::CLK_DIV1, timer16_pkg::CLK_DIV8};
      int          divs[2] = '{1, 8};
      logic [1:0]  pv;
      logic        s;
      logic [15:0] c;
      int          n;
      void'($urandom(27));
      pv = 2'($urandom());
      c = 16'($urandom_range(6, 1));
      s = 1'h0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'h1;
      rd("status", timer16_pkg::OFF_STATUS, 32'h0, 32'hFFFF_FFFF);
      rd("unmapped", 8'h30, 32'h0, 32'hFFFF_FFFF);
      rd("force", timer16_pkg::OFF_FORCE, 32'h0, 32'hFFFF_FFFF);
      // every action forced with the pin released
      wr(timer16_pkg::OFF_PORT, {30'h0, pv});
      foreach (acts[i]) begin
         wr(timer16_pkg::OFF_ACTION, {30'h0, acts[i]});
         rd("held", timer16_pkg::OFF_STATUS, stat(acts[i], s, pv), 32'hF);
         wr(timer16_pkg::OFF_FORCE, 32'h1);
         s = (acts[i] == 2'h1) ? !s : (acts[i] == 2'h0) ? s : acts[i][0];
         rd("forced", timer16_pkg::OFF_STATUS, stat(acts[i], s, pv), 32'hF);
      end
      rd("force flag", timer16_pkg::OFF_FLAGS, 32'h0, 32'h6);
      // state set up before the direction enables the pin
      wr(timer16_pkg::OFF_ACTION, 32'h2);
      @(negedge clk_sys);
      `CHK("released pin", 2'h3, level)
      @(posedge clk_sys);
      wr(timer16_pkg::OFF_PORT, {28'h0, 2'h1, pv});
      @(negedge clk_sys);
      `CHK("enabled pin", 2'h2, level)
      @(posedge clk_sys);
      // toggle half period in clear-on-match mode at two prescales
      wr(timer16_pkg::OFF_ACTION, 32'h1);
      wr(timer16_pkg::OFF_CMP_A, {16'h0, c});
      foreach (csel[k]) begin
         ctl(timer16_pkg::CLK_STOP, timer16_pkg::MODE_CTC_CMP);
         wr(timer16_pkg::OFF_COUNT, 32'h0);
         ctl(csel[k], timer16_pkg::MODE_CTC_CMP);
         half(n);
         half(n);
         `CHK("half period", divs[k] * (32'(c) + 1), n)
      end
      rd("cmp flag", timer16_pkg::OFF_FLAGS, 32'h2, 32'h2);
      // Normal wrap sets overflow, service clears it
      ctl(timer16_pkg::CLK_STOP, timer16_pkg::MODE_NORMAL);
      wr(timer16_pkg::OFF_FLAGS, 32'hF);
      wr(timer16_pkg::OFF_COUNT, 32'hFFF0);
      ctl(timer16_pkg::CLK_DIV1, timer16_pkg::MODE_NORMAL);
      repeat (30) @(posedge clk_sys);
      ctl(timer16_pkg::CLK_STOP, timer16_pkg::MODE_NORMAL);
      rd("overflow", timer16_pkg::OFF_FLAGS, 32'h1, 32'h1);
      overflow_service <= 1'h1;
      @(posedge clk_sys);
      overflow_service <= 1'h0;
      rd("serviced", timer16_pkg::OFF_FLAGS, 32'h0, 32'h1);
      // top written below count: runs to wrap before matching
      ctl(timer16_pkg::CLK_STOP, timer16_pkg::MODE_CTC_CMP);
      wr(timer16_pkg::OFF_FLAGS, 32'hF);
      wr(timer16_pkg::OFF_COUNT, 32'h64);
      ctl(timer16_pkg::CLK_DIV1, timer16_pkg::MODE_CTC_CMP);
      repeat (200) @(posedge clk_sys);
      rd("missed top", timer16_pkg::OFF_FLAGS, 32'h0, 32'h3);
      repeat (65400) @(posedge clk_sys);
      rd("wrapped", timer16_pkg::OFF_FLAGS, 32'h3, 32'h3);
      // capture value as top
      ctl(timer16_pkg::CLK_STOP, timer16_pkg::MODE_CTC_CAPT);
      wr(timer16_pkg::OFF_CAPT, 32'h5);
      wr(timer16_pkg::OFF_COUNT, 32'h0);
      wr(timer16_pkg::OFF_FLAGS, 32'hF);
      ctl(timer16_pkg::CLK_DIV1, timer16_pkg::MODE_CTC_CAPT);
      repeat (20) @(posedge clk_sys);
      rd("capt flag", timer16_pkg::OFF_FLAGS, 32'h8, 32'h8);
      rd("capt value", timer16_pkg::OFF_CAPT, 32'h5, 32'hFFFF);
      complete_run();
   end
endmodule
